// ---- dspr_pkg.sv ----
// Function
// - Four 32-bit system registers: mac high, mac low, return address, program counter.
// - Mac registers take multiply results; return register holds the subroutine return address.
// - Program counter reads as the executing instruction address plus four.
// - Two 40-bit accumulators with 8 guard bits, six 32-bit data registers.
// - Reading accumulator zero as system register returns only its low 32 bits.
// - Writing accumulator zero fills its guard bits with the written value's MSB.
// - Status bits 31 to 8 read zero; writers place zero there.
// - Bit 7 set on positive nonzero result or first operand greater.
// - Bit 6 set on zero result or equal operands.
// - Bit 5 set on negative result or first operand smaller.
// - Bit 4 set whenever the result overflowed.
// - Bits 3 to 1 select condition source: carry, negative, zero, overflow, greater, greater-equal.
// - Bit 0 is one when the selected status was achieved, else zero.
// - Conditional instructions gate only DSP register updates on the condition bit.
// - Unconditional processing updates flags, except multiply and data move kinds.
// - Conditional instructions never modify the status register.
// - Arithmetic is 40 bits; guard bits disagreeing with bit 31 mean overflow.
// - Negative flag shows true extended sign even on overflow or 32-bit destination.
// - All flags computed as if the result carried 8 guard bits.
// - Core reaches accumulator zero, X, Y registers and status as system registers.
package dspr_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ACC_W = 40;
  localparam int GUARD_W = 8;
  localparam int APB_ADDR_W = 8;
  localparam int NUM_DATA = 8;

  // ---------------------------------------------------------------
  // Register word indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_MAC_HIGH = 4'h0;
  localparam logic [3:0] IDX_MAC_LOW = 4'h1;
  localparam logic [3:0] IDX_RETURN = 4'h2;
  localparam logic [3:0] IDX_PC = 4'h3;
  localparam logic [3:0] IDX_ACC0 = 4'h4;
  localparam logic [3:0] IDX_ACC0_GUARD = 4'h5;
  localparam logic [3:0] IDX_ACC1 = 4'h6;
  localparam logic [3:0] IDX_ACC1_GUARD = 4'h7;
  localparam logic [3:0] IDX_MULT0 = 4'h8;
  localparam logic [3:0] IDX_MULT1 = 4'h9;
  localparam logic [3:0] IDX_X0 = 4'ha;
  localparam logic [3:0] IDX_X1 = 4'hb;
  localparam logic [3:0] IDX_Y0 = 4'hc;
  localparam logic [3:0] IDX_Y1 = 4'hd;
  localparam logic [3:0] IDX_STATUS = 4'he;

  // ---------------------------------------------------------------
  // Data register numbers on the datapath side
  // ---------------------------------------------------------------
  localparam logic [2:0] DR_ACC0 = 3'h0;
  localparam logic [2:0] DR_ACC1 = 3'h1;
  localparam logic [2:0] DR_MULT0 = 3'h2;
  localparam logic [2:0] DR_MULT1 = 3'h3;
  localparam logic [2:0] DR_X0 = 3'h4;
  localparam logic [2:0] DR_X1 = 3'h5;
  localparam logic [2:0] DR_Y0 = 3'h6;
  localparam logic [2:0] DR_Y1 = 3'h7;

  // ---------------------------------------------------------------
  // Status register layout
  // ---------------------------------------------------------------
  localparam int ST_GT = 7;
  localparam int ST_Z = 6;
  localparam int ST_N = 5;
  localparam int ST_V = 4;
  localparam int ST_CS_HI = 3;
  localparam int ST_CS_LO = 1;
  localparam int ST_DC = 0;
  localparam int ST_USED_W = 8;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  localparam logic [2:0] CS_CARRY = 3'h0;
  localparam logic [2:0] CS_NEG = 3'h1;
  localparam logic [2:0] CS_ZERO = 3'h2;
  localparam logic [2:0] CS_OVF = 3'h3;
  localparam logic [2:0] CS_GT = 3'h4;
  localparam logic [2:0] CS_GE = 3'h5;

  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
endpackage

// ---- dspr_regfile.sv ----
`timescale 1ns/1ns
module dspr_regfile
  import dspr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire logic insnValid,
  input wire logic [31:0] insnAddr,
  input wire logic macWrEn,
  input wire logic [31:0] macHighIn,
  input wire logic [31:0] macLowIn,
  input wire logic callValid,
  input wire logic [31:0] callReturnAddr,
  input wire logic coreWrEn,
  input wire logic [3:0] coreWrSel,
  input wire logic [31:0] coreWrData,
  input wire logic [3:0] coreRdSel,
  output logic [31:0] coreRdData,
  // DSP datapath side
  input wire logic dspValid,
  input wire logic dspConditional,
  input wire logic dspNoFlags,
  input wire logic dspCompare,
  input wire logic dspWriteDest,
  input wire logic [2:0] dspDest,
  input wire logic [ACC_W-1:0] dspResult,
  input wire logic [ACC_W-1:0] dspOpA,
  input wire logic [ACC_W-1:0] dspOpB,
  input wire logic dspCarry,
  input wire logic [2:0] dspRdSel,
  output logic [ACC_W-1:0] dspRdData,
  output logic conditionBit,
  output logic [31:0] statusOut
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0] macHigh_q;
  logic [31:0] macLow_q;
  logic [31:0] returnAddr_q;
  logic [31:0] pc_q;
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] prdata_q;
  logic [31:0] coreRdData_q;
  logic [ACC_W-1:0] dspRdData_q;
  logic [ACC_W-1:0] dataReg_q [NUM_DATA];
  logic [ACC_W-1:0] dataReg_d [NUM_DATA];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire logic [3:0] apbIdx = paddr[5:2];
  wire logic apbHit = (paddr[APB_ADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0)
                      && (apbIdx <= IDX_STATUS);
  wire logic apbSetup = psel && !penable;
  wire logic apbAccess = psel && penable;
  wire logic apbWr = apbAccess && pwrite && apbHit;

  assign pready = 1'b1;
  assign pslverr = apbAccess && !apbHit;
  assign prdata = prdata_q;

  // Core port wins over APB when both write in one cycle
  wire logic sysWrEn = coreWrEn || apbWr;
  wire logic [3:0] sysWrSel = coreWrEn ? coreWrSel : apbIdx;
  wire logic [31:0] sysWrData = coreWrEn ? coreWrData : pwdata;

  // ---------------------------------------------------------------
  // System view of the data registers
  // ---------------------------------------------------------------
  function automatic logic [3:0] sysToData(input logic [3:0] idx);
    logic [3:0] r;
    r = 4'h0;
    unique case (idx)
      IDX_ACC0: r = {1'b1, DR_ACC0};
      IDX_X0: r = {1'b1, DR_X0};
      IDX_X1: r = {1'b1, DR_X1};
      IDX_Y0: r = {1'b1, DR_Y0};
      IDX_Y1: r = {1'b1, DR_Y1};
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] readWord(input logic [3:0] idx,
                                           input logic [31:0] mh,
                                           input logic [31:0] ml,
                                           input logic [31:0] ra,
                                           input logic [31:0] pc,
                                           input logic [31:0] st,
                                           input logic [ACC_W-1:0] a0,
                                           input logic [ACC_W-1:0] a1,
                                           input logic [ACC_W-1:0] m0,
                                           input logic [ACC_W-1:0] m1,
                                           input logic [ACC_W-1:0] x0,
                                           input logic [ACC_W-1:0] x1,
                                           input logic [ACC_W-1:0] y0,
                                           input logic [ACC_W-1:0] y1);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (idx)
      IDX_MAC_HIGH: w = mh;
      IDX_MAC_LOW: w = ml;
      IDX_RETURN: w = ra;
      IDX_PC: w = pc;
      IDX_ACC0: w = a0[WORD_W-1:0];
      IDX_ACC0_GUARD: w = {24'h00_0000, a0[ACC_W-1:WORD_W]};
      IDX_ACC1: w = a1[WORD_W-1:0];
      IDX_ACC1_GUARD: w = {24'h00_0000, a1[ACC_W-1:WORD_W]};
      IDX_MULT0: w = m0[WORD_W-1:0];
      IDX_MULT1: w = m1[WORD_W-1:0];
      IDX_X0: w = x0[WORD_W-1:0];
      IDX_X1: w = x1[WORD_W-1:0];
      IDX_Y0: w = y0[WORD_W-1:0];
      IDX_Y1: w = y1[WORD_W-1:0];
      IDX_STATUS: w = st;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  wire logic [3:0] sysDataMap = sysToData(sysWrSel);
  wire logic sysDataWr = sysWrEn && sysDataMap[3];
  wire logic [2:0] sysDataIdx = sysDataMap[2:0];
  // Guard section copies the written MSB
  wire logic [ACC_W-1:0] sysDataExt = {{GUARD_W{sysWrData[WORD_W-1]}}, sysWrData};
  wire logic sysStatusWr = sysWrEn && (sysWrSel == IDX_STATUS);

  // ---------------------------------------------------------------
  // Flags from the 40-bit result
  // ---------------------------------------------------------------
  wire logic [2:0] csSel = status_q[ST_CS_HI:ST_CS_LO];
  // Sign comes from bit 39, so it stays true when bits 39:31 disagree
  wire logic resNeg = dspResult[ACC_W-1];
  wire logic resZero = (dspResult == '0);
  wire logic guardMismatch = (dspResult[ACC_W-1:WORD_W-1] != '0)
                             && (dspResult[ACC_W-1:WORD_W-1] != '1);
  wire logic cmpGt = $signed(dspOpA) > $signed(dspOpB);
  wire logic cmpEq = (dspOpA == dspOpB);
  wire logic cmpLt = $signed(dspOpA) < $signed(dspOpB);
  wire logic flagGt = dspCompare ? cmpGt : (!resNeg && !resZero);
  wire logic flagZ = dspCompare ? cmpEq : resZero;
  wire logic flagN = dspCompare ? cmpLt : resNeg;
  wire logic flagV = guardMismatch;
  logic flagDc;

  always_comb
  begin
    unique case (csSel)
      CS_CARRY: flagDc = dspCarry;
      CS_NEG: flagDc = flagN;
      CS_ZERO: flagDc = flagZ;
      CS_OVF: flagDc = flagV;
      CS_GT: flagDc = flagGt;
      CS_GE: flagDc = flagGt || flagZ;
      // Codes 110 and 111 are forbidden to software; report not achieved
      default: flagDc = 1'b0;
    endcase
  end

  // Multiply and move kinds arrive with dspNoFlags set
  wire logic flagUpdate = dspValid && !dspConditional && !dspNoFlags;
  wire logic dspExecute = dspValid && (!dspConditional || status_q[ST_DC]);
  wire logic dspDataWr = dspExecute && dspWriteDest;

  // ---------------------------------------------------------------
  // Status register
  // ---------------------------------------------------------------
  // Hardware flag update wins over a software write in the same cycle
  always_comb
  begin
    status_d = status_q;
    if (flagUpdate)
    begin
      status_d = STATUS_RESET;
      status_d[ST_GT] = flagGt;
      status_d[ST_Z] = flagZ;
      status_d[ST_N] = flagN;
      status_d[ST_V] = flagV;
      status_d[ST_CS_HI:ST_CS_LO] = csSel;
      status_d[ST_DC] = flagDc;
    end
    else if (sysStatusWr)
    begin
      status_d = {{(WORD_W-ST_USED_W){1'b0}}, sysWrData[ST_USED_W-1:0]};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      status_q <= STATUS_RESET;
    else
      status_q <= status_d;
  end

  // ---------------------------------------------------------------
  // Data registers (no reset, contents undefined after reset)
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DATA; gi++)
    begin : g_data
      // Non-accumulators keep only 32 bits; upper bits held as sign copy
      localparam bit IS_ACC = (gi < 2);
      wire logic dspHit = dspDataWr && (dspDest == 3'(gi));
      wire logic sysHit = sysDataWr && (sysDataIdx == 3'(gi));
      wire logic [ACC_W-1:0] dspVal = IS_ACC ? dspResult
        : {{GUARD_W{dspResult[WORD_W-1]}}, dspResult[WORD_W-1:0]};
      assign dataReg_d[gi] = dspHit ? dspVal : (sysHit ? sysDataExt : dataReg_q[gi]);
      always_ff @(posedge clk)
      begin
        dataReg_q[gi] <= dataReg_d[gi];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // System registers
  // ---------------------------------------------------------------
  // Multiply result beats a software write to the same register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      macHigh_q <= '0;
      macLow_q <= '0;
      returnAddr_q <= '0;
      pc_q <= '0;
    end
    else
    begin
      if (macWrEn)
      begin
        macHigh_q <= macHighIn;
        macLow_q <= macLowIn;
      end
      else
      begin
        if (sysWrEn && sysWrSel == IDX_MAC_HIGH)
          macHigh_q <= sysWrData;
        if (sysWrEn && sysWrSel == IDX_MAC_LOW)
          macLow_q <= sysWrData;
      end
      if (callValid)
        returnAddr_q <= callReturnAddr;
      else if (sysWrEn && sysWrSel == IDX_RETURN)
        returnAddr_q <= sysWrData;
      if (insnValid)
        pc_q <= insnAddr + PC_AHEAD;
    end
  end

  // ---------------------------------------------------------------
  // Read ports
  // ---------------------------------------------------------------
  wire logic [31:0] apbRdWord = readWord(apbIdx, macHigh_q, macLow_q, returnAddr_q, pc_q,
    status_q, dataReg_q[0], dataReg_q[1], dataReg_q[2], dataReg_q[3], dataReg_q[4],
    dataReg_q[5], dataReg_q[6], dataReg_q[7]);
  wire logic [31:0] coreRdWord = readWord(coreRdSel, macHigh_q, macLow_q, returnAddr_q, pc_q,
    status_q, dataReg_q[0], dataReg_q[1], dataReg_q[2], dataReg_q[3], dataReg_q[4],
    dataReg_q[5], dataReg_q[6], dataReg_q[7]);

  // Read data is captured in the setup cycle, so a same-cycle write is not seen
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_q <= '0;
      coreRdData_q <= '0;
      dspRdData_q <= '0;
    end
    else
    begin
      if (apbSetup)
        prdata_q <= (!pwrite && apbHit) ? apbRdWord : 32'h0000_0000;
      coreRdData_q <= coreRdWord;
      dspRdData_q <= dataReg_q[dspRdSel];
    end
  end

  assign coreRdData = coreRdData_q;
  assign dspRdData = dspRdData_q;
  assign conditionBit = status_q[ST_DC];
  assign statusOut = status_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_flag_op;
    flagUpdate && !dspCompare;
  endsequence

  a_pc_ahead: assert property (insnValid |=> pc_q == $past(insnAddr) + PC_AHEAD)
    else $error("pc not four ahead");
  a_mac_load: assert property (macWrEn |=> macHigh_q == $past(macHighIn)
    && macLow_q == $past(macLowIn))
    else $error("mac result lost");
  a_acc_guard_fill: assert property (sysDataWr && sysDataIdx == DR_ACC0 && !dspDataWr
    |=> dataReg_q[0][ACC_W-1:WORD_W] == {GUARD_W{dataReg_q[0][WORD_W-1]}})
    else $error("guard not sign filled");
  a_acc_read_low: assert property (coreRdSel == IDX_ACC0
    |=> coreRdData_q == $past(dataReg_q[0][WORD_W-1:0]))
    else $error("acc read not low word");
  a_status_reserved: assert property (status_q[WORD_W-1:ST_USED_W] == '0)
    else $error("reserved status bits set");
  a_cond_keeps_status: assert property (dspValid && dspConditional && !sysStatusWr
    |=> $stable(status_q))
    else $error("conditional op changed status");
  a_ovf_flag: assert property (flagUpdate |=> status_q[ST_V] == $past(guardMismatch))
    else $error("overflow flag wrong");
  a_neg_true: assert property (s_flag_op |=> status_q[ST_N] == $past(dspResult[ACC_W-1]))
    else $error("negative flag wrong");
  a_zero_flag: assert property (s_flag_op |=> status_q[ST_Z] == $past(dspResult == '0))
    else $error("zero flag wrong");
  a_dc_zero_mode: assert property (flagUpdate && csSel == CS_ZERO
    |=> status_q[ST_DC] == status_q[ST_Z])
    else $error("condition bit not zero flag");
  a_cond_skip: assert property (dspValid && dspConditional && !status_q[ST_DC]
    && dspWriteDest && !sysDataWr |=> $stable(dataReg_q[0]) && $stable(dataReg_q[4]))
    else $error("skipped op wrote register");

  sequence s_cmp_op;
    flagUpdate && dspCompare;
  endsequence

  a_gt_flag: assert property (s_flag_op
    |=> status_q[ST_GT] == $past(!dspResult[ACC_W-1] && dspResult != '0))
    else $error("greater flag wrong");
  a_cmp_gt: assert property (s_cmp_op
    |=> status_q[ST_GT] == $past($signed(dspOpA) > $signed(dspOpB)))
    else $error("compare greater wrong");
  a_cmp_neg: assert property (s_cmp_op
    |=> status_q[ST_N] == $past($signed(dspOpA) < $signed(dspOpB)))
    else $error("compare smaller wrong");
  a_cmp_zero: assert property (s_cmp_op |=> status_q[ST_Z] == $past(dspOpA == dspOpB))
    else $error("compare equal wrong");
  a_noflag_keep: assert property (dspValid && dspNoFlags && !sysStatusWr
    |=> $stable(status_q))
    else $error("flag-free op changed status");
  a_dc_carry: assert property (flagUpdate && csSel == CS_CARRY
    |=> status_q[ST_DC] == $past(dspCarry))
    else $error("condition bit not carry");
  a_dc_neg: assert property (flagUpdate && csSel == CS_NEG
    |=> status_q[ST_DC] == status_q[ST_N])
    else $error("condition bit not negative");
  a_dc_ovf: assert property (flagUpdate && csSel == CS_OVF
    |=> status_q[ST_DC] == status_q[ST_V])
    else $error("condition bit not overflow");
  a_dc_gt: assert property (flagUpdate && csSel == CS_GT
    |=> status_q[ST_DC] == status_q[ST_GT])
    else $error("condition bit not greater");
  a_dc_ge: assert property (flagUpdate && csSel == CS_GE
    |=> status_q[ST_DC] == (status_q[ST_GT] || status_q[ST_Z]))
    else $error("condition bit not greater-equal");
  a_cs_kept: assert property (flagUpdate
    |=> status_q[ST_CS_HI:ST_CS_LO] == $past(csSel))
    else $error("condition select lost");
  a_ret_load: assert property (callValid |=> returnAddr_q == $past(callReturnAddr))
    else $error("return address lost");
  a_cond_exec: assert property (dspValid && dspConditional && status_q[ST_DC]
    && dspWriteDest && dspDest == DR_X0
    |=> dataReg_q[DR_X0][WORD_W-1:0] == $past(dspResult[WORD_W-1:0]))
    else $error("enabled op did not write");
  a_sw_status: assert property (sysStatusWr && !flagUpdate
    |=> status_q[ST_USED_W-1:0] == $past(sysWrData[ST_USED_W-1:0]))
    else $error("status write lost");
endmodule

// ---- dspr_core_model.sv ----
`timescale 1ns/1ns
module dspr_core_model
  import dspr_pkg::*;
(
  input wire logic clk,
  output logic insnValid,
  output logic [31:0] insnAddr,
  output logic macWrEn,
  output logic [31:0] macHighIn,
  output logic [31:0] macLowIn,
  output logic callValid,
  output logic [31:0] callReturnAddr,
  output logic coreWrEn,
  output logic [3:0] coreWrSel,
  output logic [31:0] coreWrData,
  output logic [3:0] coreRdSel,
  output logic dspValid,
  output logic dspConditional,
  output logic dspNoFlags,
  output logic dspCompare,
  output logic dspWriteDest,
  output logic [2:0] dspDest,
  output logic [ACC_W-1:0] dspResult,
  output logic [ACC_W-1:0] dspOpA,
  output logic [ACC_W-1:0] dspOpB,
  output logic dspCarry,
  output logic [2:0] dspRdSel
);
  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  initial
  begin
    {insnValid, macWrEn, callValid, coreWrEn, dspValid} = 5'h00;
    {dspConditional, dspNoFlags, dspCompare, dspWriteDest, dspCarry} = 5'h00;
    {insnAddr, macHighIn, macLowIn, callReturnAddr, coreWrData} = '0;
    {coreWrSel, coreRdSel, dspDest, dspRdSel} = '0;
    {dspResult, dspOpA, dspOpB} = '0;
  end

  // ---------------------------------------------------------------
  // Core pulses: 0 fetch, 1 multiply result, 2 call, 3 register write
  // ---------------------------------------------------------------
  // Data lines flip after the pulse so a stale value never looks valid
  task automatic core(input logic [1:0] k, input logic [3:0] s, input logic [31:0] d, e);
    @(posedge clk);
    {insnValid, macWrEn, callValid, coreWrEn} <= 4'h8 >> k;
    {insnAddr, macHighIn, macLowIn, callReturnAddr} <= {d, d, e, d};
    coreWrSel <= s;
    coreWrData <= d;
    @(posedge clk);
    {insnValid, macWrEn, callValid, coreWrEn} <= 4'h0;
    {insnAddr, macHighIn, macLowIn, callReturnAddr, coreWrData} <= ~{d, d, e, d, d};
  endtask

  // ---------------------------------------------------------------
  // Datapath operation; ctl is {cond, noFlags, compare, writeDest, carry}
  // ---------------------------------------------------------------
  task automatic dspOp(input logic [4:0] c, input logic [2:0] dst, input logic [39:0] r, a, b);
    @(posedge clk);
    dspValid <= 1'b1;
    {dspConditional, dspNoFlags, dspCompare, dspWriteDest, dspCarry} <= c;
    {dspDest, dspResult, dspOpA, dspOpB} <= {dst, r, a, b};
    @(posedge clk);
    dspValid <= 1'b0;
    {dspResult, dspOpA, dspOpB} <= ~{r, a, b};
  endtask

  task automatic sel(input logic [3:0] c, input logic [2:0] d);
    @(posedge clk);
    coreRdSel <= c;
    dspRdSel <= d;
  endtask
endmodule

// ---- dsp_register_file_status_tb_top.sv ----
`timescale 1ns/1ns
module dsp_register_file_status_tb_top
  import dspr_pkg::*;
;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, coreRdData, statusOut, insnAddr, macHighIn, macLowIn;
  logic [31:0] callReturnAddr, coreWrData;
  logic pready, pslverr, conditionBit, insnValid, macWrEn, callValid, coreWrEn, dspValid;
  logic dspConditional, dspNoFlags, dspCompare, dspWriteDest, dspCarry;
  logic [3:0] coreWrSel, coreRdSel;
  logic [2:0] dspDest, dspRdSel;
  logic [39:0] dspResult, dspOpA, dspOpB, dspRdData;
  int failures = 0, numChecks = 0;

  always #10 clk = ~clk;

  dspr_regfile DUT (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .insnValid, .insnAddr, .macWrEn, .macHighIn, .macLowIn, .callValid,
    .callReturnAddr, .coreWrEn, .coreWrSel, .coreWrData, .coreRdSel, .coreRdData, .dspValid,
    .dspConditional, .dspNoFlags, .dspCompare, .dspWriteDest, .dspDest, .dspResult, .dspOpA,
    .dspOpB, .dspCarry, .dspRdSel, .dspRdData, .conditionBit, .statusOut);

  dspr_core_model m (.clk, .insnValid, .insnAddr, .macWrEn, .macHighIn, .macLowIn, .callValid,
    .callReturnAddr, .coreWrEn, .coreWrSel, .coreWrData, .coreRdSel, .dspValid,
    .dspConditional, .dspNoFlags, .dspCompare, .dspWriteDest, .dspDest, .dspResult, .dspOpA,
    .dspOpB, .dspCarry, .dspRdSel);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, exp);
    numChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Master never assumes a latency: it waits for pready under a bound
  task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      summarize();
    end
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask

  task automatic rdchk(input logic [3:0] i, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, i, 32'h0, r, e);
    chk({7'h00, e, r}, {8'h00, x});
  endtask

  function automatic logic [7:0] expSt(input logic [39:0] r, a, b, input logic cmp, cy,
                                       input logic [2:0] cs);
    logic n, z, g, v, dc;
    v = !(&r[39:31] || ~|r[39:31]);
    n = cmp ? ($signed(a) < $signed(b)) : r[39];
    z = cmp ? (a == b) : (r == 40'h0);
    g = cmp ? ($signed(a) > $signed(b)) : (!n && !z);
    dc = (cs == 3'h0) ? cy : (cs == 3'h1) ? n : (cs == 3'h2) ? z : (cs == 3'h3) ? v :
         (cs == 3'h4) ? g : (g | z);
    return {g, z, n, v, cs, dc};
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic tReset;
    logic [31:0] r;
    logic e;
    chk(statusOut, 32'h0);
    apb(1'b0, 4'hf, 32'h0, r, e);
    chk({e, r}, 33'h1_0000_0000);
    wr(IDX_STATUS, 32'hffff_ffff);
    rdchk(IDX_STATUS, 32'h0000_00ff);
    // Second reset in mid-run must clear the flags again
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1 chk(statusOut, 32'h0);
    @(posedge clk);
    reset_n <= 1'b1;
  endtask

  task automatic tSystem;
    m.core(2'h1, 4'h0, 32'hdead_0001, 32'h0bad_0002);
    rdchk(IDX_MAC_HIGH, 32'hdead_0001);
    rdchk(IDX_MAC_LOW, 32'h0bad_0002);
    m.core(2'h2, 4'h0, 32'h0000_2468, 32'h0);
    rdchk(IDX_RETURN, 32'h0000_2468);
    m.core(2'h0, 4'h0, 32'h0000_1000, 32'h0);
    wr(IDX_PC, 32'h0000_0005);
    rdchk(IDX_PC, 32'h0000_1004);
    wr(IDX_MAC_HIGH, 32'h89ab_cdef);
    rdchk(IDX_MAC_HIGH, 32'h89ab_cdef);
    m.core(2'h3, IDX_X1, 32'h1357_9bdf, 32'h0);
    rdchk(IDX_X1, 32'h1357_9bdf);
    wr(IDX_Y1, 32'h0f0f_0f0f);
    rdchk(IDX_Y1, 32'h0f0f_0f0f);
  endtask

  task automatic tAccum;
    wr(IDX_ACC0, 32'h8000_0001);
    rdchk(IDX_ACC0, 32'h8000_0001);
    rdchk(IDX_ACC0_GUARD, 32'h0000_00ff);
    m.sel(IDX_ACC0, DR_ACC0);
    @(posedge clk);
    #1 chk(dspRdData, 40'hff_8000_0001);
    chk(coreRdData, 32'h8000_0001);
    wr(IDX_ACC0, 32'h7fff_ffff);
    rdchk(IDX_ACC0_GUARD, 32'h0000_0000);
  endtask

  task automatic tFlags;
    logic [39:0] res [5] = '{40'h0, 40'h1, 40'hff_ffff_ffff, 40'h00_8000_0000, 40'hff_0000_0000};
    logic [39:0] pa [4] = '{40'h5, 40'h3, 40'h4, 40'hff_ffff_ffff};
    logic [39:0] pb [4] = '{40'h3, 40'h5, 40'h4, 40'h1};
    m.sel(IDX_ACC0, DR_ACC1);
    for (int cs = 0; cs < 6; cs++)
    begin
      wr(IDX_STATUS, {28'h0, cs[2:0], 1'b0});
      for (int i = 0; i < 5; i++)
      begin
        m.dspOp({4'b0001, i[0]}, DR_ACC1, res[i], 40'h0, 40'h0);
        #1 chk(statusOut, {24'h0, expSt(res[i], 40'h0, 40'h0, 1'b0, i[0], cs[2:0])});
        chk(conditionBit, expSt(res[i], 40'h0, 40'h0, 1'b0, i[0], cs[2:0]) & 8'h01);
        @(posedge clk);
        #1 chk(dspRdData, res[i]);
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      m.dspOp(5'b00100, DR_ACC1, 40'h0, pa[i], pb[i]);
      #1 chk(statusOut, {24'h0, expSt(40'h0, pa[i], pb[i], 1'b1, 1'b0, CS_GE)});
    end
  endtask

  task automatic tCond;
    logic [31:0] st;
    wr(IDX_STATUS, {28'h0, CS_ZERO, 1'b0});
    m.dspOp(5'b00000, DR_X0, 40'h0, 40'h0, 40'h0);
    #1 st = statusOut;
    m.dspOp(5'b10010, DR_X0, 40'h00_0000_1234, 40'h0, 40'h0);
    #1 chk(statusOut, st);
    rdchk(IDX_X0, 32'h0000_1234);
    m.dspOp(5'b00000, DR_X0, 40'h1, 40'h0, 40'h0);
    #1 st = statusOut;
    chk(st, 32'h0000_0084);
    m.dspOp(5'b10010, DR_X0, 40'h00_0000_5678, 40'h0, 40'h0);
    #1 chk(statusOut, st);
    rdchk(IDX_X0, 32'h0000_1234);
    m.dspOp(5'b01010, DR_Y0, 40'h0, 40'h0, 40'h0);
    #1 chk(statusOut, st);
    rdchk(IDX_Y0, 32'h0000_0000);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    tReset();
    tSystem();
    tAccum();
    tFlags();
    tCond();
    summarize();
  end
endmodule
